// ===== src/assert_call_const_exec_unit.sv
// execution unit for asserts, calls, constant loads, clz, byte compare and trap hooks
`timescale 1ns/1ps

module assert_call_const_exec_unit #(
  parameter logic [7:0] OPC_ASSERT_LE_UNSIGNED = 8'h60,
  parameter logic [7:0] OPC_ASSERT_LT_SIGNED   = 8'h62,
  parameter logic [7:0] OPC_CALL               = 8'ha8,
  parameter logic [7:0] OPC_CALL_INDIRECT      = 8'hc8,
  parameter logic [7:0] OPC_CLASSIFY           = 8'he6,
  parameter logic [7:0] OPC_COUNT_LEAD_ZEROS   = 8'h08,
  parameter logic [7:0] OPC_LOAD_CONST         = 8'h04,
  parameter logic [7:0] OPC_LOAD_CONST_ONES    = 8'h06,
  parameter logic [7:0] CLASSIFY_TRAP_VEC      = 8'h80,
  parameter logic [7:0] CONVERT_TRAP_VEC       = 8'h81
) (
  input  wire logic        core_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o
);
  import exec_unit_pkg::*;

  // software-visible state
  logic [31:0] instr_ff;
  logic [31:0] opa_ff;
  logic [31:0] opb_ff;
  logic [31:0] pc_ff;
  logic [31:0] mode_ff;
  logic [31:0] sp_ff;
  logic [31:0] result_ff;
  logic [31:0] status_ff;
  logic [31:0] nxt_pc_ff;
  logic [31:0] ptr_first_ff;
  logic [31:0] ptr_second_ff;
  logic [31:0] ptr_target_ff;

  // bus data-phase bookkeeping
  logic        wr_pend_ff;
  logic        rd_pend_ff;
  logic [7:0]  addr_ff;
  logic        go;
  logic        addr_phase;

  exec_out_s   ex;
  op_kind_e    kind;

  // return address past the delay slot
  function automatic logic [31:0] link_addr(input logic [31:0] pc);
    return pc + LINK_OFFSET;
  endfunction

  function automatic logic any_lane_equal(input logic [31:0] a, input logic [31:0] b);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < BYTE_LANES; i++) begin
      if (a[LANE_W*i +: LANE_W] == b[LANE_W*i +: LANE_W]) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  function automatic logic [5:0] count_zeros(input logic [31:0] v);
    logic [5:0] n;
    logic       hit;
    n   = 6'd32;
    hit = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      if (!hit && v[i]) begin
        n   = 6'(31 - i);
        hit = 1'b1;
      end
    end
    return n;
  endfunction

  function automatic logic [31:0] classify(input logic        sign,
                                           input logic [10:0] bexp,
                                           input logic [10:0] emax,
                                           input logic        fzero,
                                           input logic        fones,
                                           input logic        fmsb);
    logic [4:0] cls_code;
    logic [1:0] sub;
    sub = fzero ? 2'b00 : (fones ? 2'b11 : 2'b10);
    if (bexp == '0) begin
      cls_code = {3'b000, sub};
    end else if (bexp == 11'd1) begin
      cls_code = {3'b001, sub};
    end else if (bexp < emax) begin
      cls_code = {3'b010, sub};
    end else if (bexp == emax) begin
      cls_code = {3'b011, sub};
    end else begin
      cls_code = fzero ? 5'b10000 : (fmsb ? 5'b10011 : 5'b10010);
    end
    return {26'h000_0000, sign, cls_code};
  endfunction

  // second operand: register or zero-extended 8-bit immediate
  logic [31:0] src_b;
  logic [7:0]  opc;
  logic [7:0]  fld_c;
  logic [7:0]  fld_a;
  logic [7:0]  fld_b;
  logic [15:0] imm16;
  assign opc   = instr_ff[OP_MSB:OP_LSB];
  assign fld_c = instr_ff[FC_MSB:FC_LSB];
  assign fld_a = instr_ff[FA_MSB:FA_LSB];
  assign fld_b = instr_ff[FB_MSB:FB_LSB];
  assign imm16 = {fld_c, fld_b};
  assign src_b = opc[0] ? {24'h00_0000, fld_b} : opb_ff;

  // conversion control fields carried in the low byte
  logic        unsigned_integer_bit;
  logic [2:0]  rounding_field;
  logic [1:0]  result_target_format_field;
  logic [1:0]  source_format_field;
  assign unsigned_integer_bit = fld_b[7];
  assign rounding_field       = fld_b[6:4];
  assign result_target_format_field    = fld_b[3:2];
  assign source_format_field  = fld_b[1:0];

  // fraction extremes of the first operand in both widths
  logic        sgl_frac_zero;
  logic        sgl_frac_ones;
  logic        dbl_frac_zero;
  logic        dbl_frac_ones;
  assign sgl_frac_zero = opa_ff[22:0] == '0;
  assign sgl_frac_ones = &opa_ff[22:0];
  assign dbl_frac_zero = {opa_ff[19:0], opb_ff} == '0;
  assign dbl_frac_ones = &{opa_ff[19:0], opb_ff};

  always_comb begin
    case ({opc[7:1], 1'b0})
      OPC_ASSERT_LE_UNSIGNED: kind = KIND_AS_LEU;
      OPC_ASSERT_LT_SIGNED:   kind = KIND_AS_LT;
      OPC_ASSERT_LT_UNSIGNED: kind = KIND_AS_LTU;
      OPC_ASSERT_NOT_EQUAL:   kind = KIND_AS_NEQ;
      OPC_CALL:               kind = KIND_CALL;
      OPC_CALL_INDIRECT:      kind = KIND_CALL_IN;
      OPC_CLASSIFY:           kind = KIND_CLASS;
      OPC_COUNT_LEAD_ZEROS:   kind = KIND_LEAD_ZERO;
      OPC_LOAD_CONST:         kind = KIND_CONST;
      OPC_LOAD_CONST_HIGH:    kind = KIND_CONST_H;
      OPC_LOAD_CONST_ONES:    kind = KIND_CONST_N;
      OPC_CONVERT:            kind = KIND_CONVERT;
      OPC_BYTE_LANE_COMPARE:  kind = KIND_BYTE_CMP;
      default:                kind = KIND_NONE;
    endcase
  end

  // classification of the first operand, shown for the trap handler
  logic [31:0] class_word;
  always_comb begin
    case (source_format_field)
      FMT_SINGLE: class_word = classify(opa_ff[31], {3'b000, opa_ff[30:23]}, MAX_BEXP_SGL,
                                        sgl_frac_zero, sgl_frac_ones, opa_ff[22]);
      FMT_DOUBLE: class_word = classify(opa_ff[31], opa_ff[30:20], MAX_BEXP_DBL,
                                        dbl_frac_zero, dbl_frac_ones, opa_ff[19]);
      default:    class_word = 32'h0000_0000;
    endcase
  end

  logic        pass;
  logic [29:0] call_word;
  always_comb begin
    ex        = '0;
    ex.nxt_pc = pc_ff + INSTR_STEP;
    ex.result_target   = fld_c;
    pass      = 1'b1;
    call_word = opc[0] ? {14'h0000, imm16}
                       : pc_ff[31:2] + {{14{imm16[15]}}, imm16};
    case (kind)
      KIND_AS_LEU: pass = opa_ff <= src_b;
      KIND_AS_LT:  pass = $signed(opa_ff) < $signed(src_b);
      KIND_AS_LTU: pass = opa_ff < src_b;
      KIND_AS_NEQ: pass = opa_ff != src_b;
      KIND_CALL: begin
        ex.result = link_addr(pc_ff);
        ex.result_target   = fld_a;
        ex.reg_wr = 1'b1;
        ex.branch = 1'b1;
        ex.nxt_pc = {call_word, 2'b00};
      end
      KIND_CALL_IN: begin
        ex.result = link_addr(pc_ff);
        ex.result_target   = fld_a;
        ex.reg_wr = 1'b1;
        ex.branch = 1'b1;
        ex.nxt_pc = opb_ff;
      end
      KIND_CLASS: begin
        ex.trap   = 1'b1;
        ex.vector = CLASSIFY_TRAP_VEC;
        ex.ptr_first  = fld_a;
        ex.ptr_target = fld_c;
        ex.ptr_second = {30'h0000_0000, source_format_field};
      end
      KIND_LEAD_ZERO: begin
        ex.result = {26'h000_0000, count_zeros(src_b)};
        ex.reg_wr = 1'b1;
      end
      KIND_CONST: begin
        ex.result = {16'h0000, imm16};
        ex.result_target   = fld_a;
        ex.reg_wr = 1'b1;
      end
      KIND_CONST_H: begin
        ex.result = {imm16, opa_ff[15:0]};
        ex.result_target   = fld_a;
        ex.reg_wr = 1'b1;
      end
      KIND_CONST_N: begin
        ex.result = {16'hffff, imm16};
        ex.result_target   = fld_a;
        ex.reg_wr = 1'b1;
      end
      KIND_CONVERT: begin
        ex.trap   = 1'b1;
        ex.vector = CONVERT_TRAP_VEC;
        ex.ptr_first  = fld_a;
        ex.ptr_target = fld_c;
        // stack pointer is folded in when the unsigned bit is set
        ex.ptr_second = {24'h00_0000, fld_b} + (unsigned_integer_bit ? sp_ff : 32'h0000_0000);
        ex.rsv_round  = rounding_field > ROUND_MAX_VALID;
        ex.same_fmt   = result_target_format_field == source_format_field;
      end
      KIND_BYTE_CMP: begin
        ex.result = any_lane_equal(opa_ff, src_b) ? BOOL_TRUE : BOOL_FALSE;
        ex.reg_wr = 1'b1;
      end
      default: ex.unknown = 1'b1;
    endcase
    if (!pass) begin
      // failed assert: no register write, vector or protection trap
      ex.trap   = 1'b1;
      ex.vector = fld_c;
      ex.prot   = mode_ff[MODE_USER_BIT] && (fld_c <= USER_VEC_MAX);
    end
  end

  // AHB-Lite slave, zero wait states, always OKAY
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;
  assign addr_phase  = hsel_i && hready_i && htrans_i[1];
  assign go          = wr_pend_ff && (addr_ff == OFS_CTRL) && hwdata_i[CTRL_GO_BIT];

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      addr_ff    <= 8'h00;
    end else if (hready_i) begin
      wr_pend_ff <= addr_phase && hwrite_i;
      rd_pend_ff <= addr_phase && !hwrite_i;
      addr_ff    <= haddr_i[7:0];
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      instr_ff <= 32'h0000_0000;
      opa_ff   <= 32'h0000_0000;
      opb_ff   <= 32'h0000_0000;
      pc_ff    <= 32'h0000_0000;
      mode_ff  <= 32'h0000_0000;
      sp_ff    <= 32'h0000_0000;
    end else if (wr_pend_ff) begin
      case (addr_ff)
        OFS_INSTR: instr_ff <= hwdata_i;
        OFS_OPA:   opa_ff   <= hwdata_i;
        OFS_OPB:   opb_ff   <= hwdata_i;
        OFS_PC:    pc_ff    <= hwdata_i;
        OFS_MODE:  mode_ff  <= {24'h00_0000,
                                hwdata_i[MODE_FLAG_LSB +: MODE_FLAG_W], 3'b000,
                                hwdata_i[MODE_USER_BIT]};
        OFS_SP:    sp_ff    <= hwdata_i;
        default:   ;
      endcase
    end
  end

  logic [31:0] status_word;
  logic        ptr_load;
  assign status_word = {8'h00, ex.result_target, ex.vector, 1'b0, ex.unknown, ex.same_fmt,
                        ex.rsv_round, ex.branch, ex.reg_wr, ex.prot, ex.trap};

  // results; the flag bits in the mode register are never touched here
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      result_ff <= 32'h0000_0000;
      status_ff <= 32'h0000_0000;
      nxt_pc_ff <= 32'h0000_0000;
    end else if (go) begin
      result_ff <= ex.result;
      nxt_pc_ff <= ex.nxt_pc;
      status_ff <= status_word;
    end
  end

  // trap pointers change only when a classify or convert hook traps
  assign ptr_load = go && ex.trap && !ex.prot &&
                    (kind == KIND_CLASS || kind == KIND_CONVERT);

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ptr_first_ff  <= 32'h0000_0000;
      ptr_second_ff <= 32'h0000_0000;
      ptr_target_ff <= 32'h0000_0000;
    end else if (ptr_load) begin
      ptr_first_ff  <= {24'h00_0000, ex.ptr_first};
      ptr_second_ff <= ex.ptr_second;
      ptr_target_ff <= {24'h00_0000, ex.ptr_target};
    end
  end

  always_comb begin
    hrdata_o = 32'h0000_0000;
    if (rd_pend_ff) begin
      case (addr_ff)
        OFS_INSTR:  hrdata_o = instr_ff;
        OFS_OPA:    hrdata_o = opa_ff;
        OFS_OPB:    hrdata_o = opb_ff;
        OFS_PC:     hrdata_o = pc_ff;
        OFS_MODE:   hrdata_o = mode_ff;
        OFS_SP:     hrdata_o = sp_ff;
        OFS_RESULT: hrdata_o = result_ff;
        OFS_STATUS: hrdata_o = status_ff;
        OFS_NXT_PC: hrdata_o = nxt_pc_ff;
        OFS_PTR_FIRST:  hrdata_o = ptr_first_ff;
        OFS_PTR_SECOND: hrdata_o = ptr_second_ff;
        OFS_PTR_TARGET: hrdata_o = ptr_target_ff;
        OFS_CLASS:  hrdata_o = class_word;
        default:    hrdata_o = 32'h0000_0000;
      endcase
    end
  end

endmodule // assert_call_const_exec_unit

// ===== include/exec_unit_pkg.sv
// package: register map, instruction fields and encodings of the assert/call/constant unit
package exec_unit_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_INSTR   = 8'h00;
  localparam logic [7:0] OFS_OPA     = 8'h04;
  localparam logic [7:0] OFS_OPB     = 8'h08;
  localparam logic [7:0] OFS_PC      = 8'h0c;
  localparam logic [7:0] OFS_MODE    = 8'h10;
  localparam logic [7:0] OFS_SP      = 8'h14;
  localparam logic [7:0] OFS_CTRL    = 8'h18;
  localparam logic [7:0] OFS_RESULT  = 8'h20;
  localparam logic [7:0] OFS_STATUS  = 8'h24;
  localparam logic [7:0] OFS_NXT_PC  = 8'h28;
  localparam logic [7:0] OFS_PTR_FIRST  = 8'h2c;
  localparam logic [7:0] OFS_PTR_SECOND = 8'h30;
  localparam logic [7:0] OFS_PTR_TARGET = 8'h34;
  localparam logic [7:0] OFS_CLASS   = 8'h38;

  // mode and control bits
  localparam int MODE_USER_BIT  = 0;
  localparam int MODE_FLAG_LSB  = 4;
  localparam int MODE_FLAG_W    = 4;
  localparam int CTRL_GO_BIT    = 0;

  // status bits
  localparam int ST_TRAP       = 0;
  localparam int ST_PROT       = 1;
  localparam int ST_REG_WR     = 2;
  localparam int ST_BRANCH     = 3;
  localparam int ST_RSV_ROUND  = 4;
  localparam int ST_SAME_FMT   = 5;
  localparam int ST_UNKNOWN    = 6;
  localparam int ST_VEC_LSB    = 8;
  localparam int ST_RESULT_TARGET_LSB   = 16;

  // instruction fields
  localparam int OP_MSB = 31;
  localparam int OP_LSB = 24;
  localparam int FC_MSB = 23;
  localparam int FC_LSB = 16;
  localparam int FA_MSB = 15;
  localparam int FA_LSB = 8;
  localparam int FB_MSB = 7;
  localparam int FB_LSB = 0;

  // documented opcodes (register form; immediate form has bit 0 set)
  localparam logic [7:0] OPC_ASSERT_LT_UNSIGNED = 8'h52;
  localparam logic [7:0] OPC_ASSERT_NOT_EQUAL   = 8'h72;
  localparam logic [7:0] OPC_LOAD_CONST_HIGH    = 8'h02;
  localparam logic [7:0] OPC_BYTE_LANE_COMPARE  = 8'h2e;
  localparam logic [7:0] OPC_CONVERT            = 8'he4;

  localparam logic [7:0]  USER_VEC_MAX  = 8'h3f;
  localparam logic [31:0] LINK_OFFSET   = 32'h0000_0008;
  localparam logic [31:0] INSTR_STEP    = 32'h0000_0004;
  localparam int          BYTE_LANES    = 4;
  localparam int          LANE_W        = 8;
  localparam logic [31:0] BOOL_TRUE     = 32'h8000_0000;
  localparam logic [31:0] BOOL_FALSE    = 32'h0000_0000;
  localparam logic [10:0] MAX_BEXP_SGL  = 11'd254;
  localparam logic [10:0] MAX_BEXP_DBL  = 11'd2046;
  localparam logic [1:0]  FMT_INT       = 2'b00;
  localparam logic [1:0]  FMT_SINGLE    = 2'b01;
  localparam logic [1:0]  FMT_DOUBLE    = 2'b10;
  localparam logic [2:0]  ROUND_MAX_VALID = 3'b100;

  typedef enum logic [3:0] {
    KIND_NONE    = 4'b0000,
    KIND_AS_LEU  = 4'b0001,
    KIND_AS_LT   = 4'b0010,
    KIND_AS_LTU  = 4'b0011,
    KIND_AS_NEQ  = 4'b0100,
    KIND_CALL    = 4'b0101,
    KIND_CALL_IN = 4'b0110,
    KIND_CLASS   = 4'b0111,
    KIND_LEAD_ZERO = 4'b1000,
    KIND_CONST   = 4'b1001,
    KIND_CONST_H = 4'b1010,
    KIND_CONST_N = 4'b1011,
    KIND_CONVERT = 4'b1100,
    KIND_BYTE_CMP = 4'b1101
  } op_kind_e;

  typedef struct packed {
    logic [31:0] result;
    logic [31:0] nxt_pc;
    logic [31:0] ptr_second;
    logic [7:0]  ptr_first;
    logic [7:0]  ptr_target;
    logic [7:0]  result_target;
    logic [7:0]  vector;
    logic        reg_wr;
    logic        trap;
    logic        prot;
    logic        branch;
    logic        rsv_round;
    logic        same_fmt;
    logic        unknown;
  } exec_out_s;

endpackage

// ===== bench/exec_unit_asserts.sv
// bus-level checks for the assert, call and constant execution unit
`timescale 1ns/1ps
module exec_unit_asserts
  import exec_unit_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  input  wire logic [31:0] hrdata_o,
  input  wire logic        hreadyout_o,
  input  wire logic        hresp_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  // read address phase at an offset, then its data phase
  sequence rd_at(logic [7:0] ofs);
    hsel_i && hready_i && htrans_i[1] && !hwrite_i && haddr_i[7:0] == ofs ##1 1'b1;
  endsequence
  sequence no_rd;
    !(hsel_i && hready_i && htrans_i[1] && !hwrite_i);
  endsequence

  a_resp_okay: assert property (hresp_o == 1'b0)
    else $error("bus response not okay");
  a_ready_high: assert property (hreadyout_o == 1'b1)
    else $error("slave inserted a wait state");
  a_idle_rdata_zero: assert property (no_rd |=> hrdata_o == 32'h0)
    else $error("read data driven outside a read");
  a_mode_flags_kept: assert property (
    rd_at(OFS_MODE) |-> hrdata_o[31:8] == 24'h0 && hrdata_o[3:1] == 3'h0)
    else $error("mode register shows stray bits");
  a_class_upper_zero: assert property (rd_at(OFS_CLASS) |-> hrdata_o[31:6] == 26'h0)
    else $error("class word upper bits not zero");
  a_class_code_legal: assert property (
    rd_at(OFS_CLASS) |-> hrdata_o[1:0] != 2'b01 && hrdata_o[4:0] <= 5'h13)
    else $error("class code is an unused value");
  a_prot_is_trap: assert property (
    rd_at(OFS_STATUS) |-> !hrdata_o[1] || (hrdata_o[0] && hrdata_o[15:8] <= USER_VEC_MAX))
    else $error("protection flag without low-vector trap");
  a_trap_no_write: assert property (rd_at(OFS_STATUS) |-> !(hrdata_o[0] && hrdata_o[2]))
    else $error("trap reported together with register write");
endmodule // exec_unit_asserts

bind assert_call_const_exec_unit exec_unit_asserts u_asserts (.core_clk_i, .reset_n_i, .hsel_i,
  .haddr_i, .htrans_i, .hwrite_i, .hsize_i, .hwdata_i, .hready_i, .hrdata_o, .hreadyout_o,
  .hresp_o);

// ===== bench/assert_call_const_exec_unit_test.sv
// self-checking testbench for the assert, call and constant execution unit
`timescale 1ns/1ps
module assert_call_const_exec_unit_test;
  import exec_unit_pkg::*;
  localparam logic [31:0] PN = 32'h0000_1004;
  logic        core_clk_i = 1'b0;
  logic        reset_n_i  = 1'b0;
  logic        hsel       = 1'b1;
  logic [31:0] haddr      = 32'h0;
  logic [1:0]  htrans     = 2'b00;
  logic        hwrite     = 1'b0;
  logic [31:0] hwdata     = 32'h0;
  wire  [31:0] hrdata;
  wire         hready;
  wire         hresp;
  logic [31:0] rd;
  int          n_fail      = 0;
  int          checks_done = 0;

  always #20 core_clk_i = ~core_clk_i;

  assert_call_const_exec_unit uut (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
    .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
    .hresp_o(hresp));

  // one single-word transfer; read data lands in rd
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge core_clk_i);
    haddr  <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge core_clk_i); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge core_clk_i); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic ex(input logic [31:0] ins, a, b, r, input logic [7:0] f, v,
                    input logic [31:0] np);
    bus(OFS_INSTR, 1'b1, ins);
    bus(OFS_OPA, 1'b1, a);
    bus(OFS_OPB, 1'b1, b);
    bus(OFS_CTRL, 1'b1, 32'h1);
    bus(OFS_STATUS, 1'b0, 32'h0);
    chk("status flags", {25'h0, f[6:0]}, {25'h0, rd[6:0]});
    if (f[0]) chk("trap vector", {24'h0, v}, {24'h0, rd[15:8]});
    bus(OFS_NXT_PC, 1'b0, 32'h0);
    chk("next pc", np, rd);
    if (!v[7]) begin
      bus(OFS_RESULT, 1'b0, 32'h0);
      chk("result", r, rd);
    end
  endtask

  task automatic cls(input logic [1:0] fs, input logic [31:0] a, b, e);
    bus(OFS_INSTR, 1'b1, {24'he60703, 6'h0, fs});
    bus(OFS_OPA, 1'b1, a);
    bus(OFS_OPB, 1'b1, b);
    bus(OFS_CLASS, 1'b0, 32'h0);
    chk("class word", e, rd);
  endtask

  task automatic conv(input logic [7:0] fld, input logic [7:0] f, input logic [31:0] second_indirect_pointer);
    ex({24'he40903, fld}, 32'h3f80_0000, 32'h0, 32'h0, f, 8'h81, PN);
    bus(OFS_PTR_SECOND, 1'b0, 32'h0);
    chk("second pointer", second_indirect_pointer, rd);
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #(40 * 6000);
    n_fail++;
    finish_test;
  end

  initial begin
    repeat (5) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    bus(OFS_PC, 1'b1, 32'h1000);
    bus(OFS_SP, 1'b1, 32'h100);
    bus(OFS_MODE, 1'b1, 32'h50);
    ex(32'h6040_0102, 32'h5, 32'h5, 32'h0, 8'h00, 8'h00, PN);
    ex(32'h6040_0102, 32'h6, 32'h5, 32'h0, 8'h01, 8'h40, PN);
    ex(32'h6241_0102, 32'hffff_ffff, 32'h0, 32'h0, 8'h00, 8'h00, PN);
    ex(32'h6241_0102, 32'h0, 32'h0, 32'h0, 8'h01, 8'h41, PN);
    ex(32'h5242_0102, 32'hffff_ffff, 32'h0, 32'h0, 8'h01, 8'h42, PN);
    ex(32'h5342_0104, 32'h3, 32'h0, 32'h0, 8'h00, 8'h00, PN);
    ex(32'h7244_0102, 32'h7, 32'h7, 32'h0, 8'h01, 8'h44, PN);
    ex(32'h7344_01ff, 32'hffff_ffff, 32'hffff_ffff, 32'h0, 8'h00, 8'h00, PN);
    bus(OFS_MODE, 1'b1, 32'h51);
    ex(32'h723f_0102, 32'h7, 32'h7, 32'h0, 8'h03, 8'h3f, PN);
    ex(32'h7240_0102, 32'h7, 32'h7, 32'h0, 8'h01, 8'h40, PN);
    bus(OFS_MODE, 1'b1, 32'h50);
    ex(32'ha8ff_05ff, 32'h0, 32'h0, 32'h1008, 8'h0c, 8'h00, 32'hffc);
    ex(32'ha900_0510, 32'h0, 32'h0, 32'h1008, 8'h0c, 8'h00, 32'h40);
    ex(32'hc800_0502, 32'h0, 32'h2000, 32'h1008, 8'h0c, 8'h00, 32'h2000);
    ex(32'h0807_0002, 32'h0, 32'h0, 32'd32, 8'h04, 8'h00, PN);
    ex(32'h0807_0002, 32'h0, 32'h8000_0000, 32'h0, 8'h04, 8'h00, PN);
    ex(32'h0907_0001, 32'h0, 32'h0, 32'd31, 8'h04, 8'h00, PN);
    ex(32'h0480_0201, 32'h0, 32'h0, 32'h0000_8001, 8'h04, 8'h00, PN);
    ex(32'h0680_0201, 32'h0, 32'h0, 32'hffff_8001, 8'h04, 8'h00, PN);
    ex(32'h0280_0201, 32'h1234_5678, 32'h0, 32'h8001_5678, 8'h04, 8'h00, PN);
    ex(32'h2e07_0102, 32'h1122_3344, 32'h5566_3377, BOOL_TRUE, 8'h04, 8'h00, PN);
    ex(32'h2e07_0102, 32'h1122_3344, 32'h4433_2211, BOOL_FALSE, 8'h04, 8'h00, PN);
    ex(32'he607_0301, 32'hff80_0000, 32'h0, 32'h0, 8'h01, 8'h80, PN);
    bus(OFS_PTR_FIRST, 1'b0, 32'h0);
    chk("first pointer", 32'h3, rd);
    bus(OFS_PTR_SECOND, 1'b0, 32'h0);
    chk("second pointer", 32'h1, rd);
    bus(OFS_PTR_TARGET, 1'b0, 32'h0);
    chk("result_target pointer", 32'h7, rd);
    cls(2'b01, 32'hff80_0000, 32'h0, 32'h30);
    cls(2'b01, 32'h8000_0000, 32'h0, 32'h20);
    cls(2'b01, 32'h7fc0_0000, 32'h0, 32'h13);
    cls(2'b01, 32'h7f80_0001, 32'h0, 32'h12);
    cls(2'b01, 32'h7f00_0000, 32'h0, 32'h0c);
    cls(2'b10, 32'h7fe0_0000, 32'h0, 32'h0c);
    conv(8'hc4, 8'h01, 32'h1c4);
    chk("recovered field", 32'h0000_00c4, rd - 32'h0000_0100);
    for (int i = 0; i < 8; i++) begin
      conv({1'b0, i[2:0], 4'h4}, (i > 4) ? 8'h11 : 8'h01, {25'h0, i[2:0], 4'h4});
    end
    for (int i = 0; i < 9; i++) begin
      conv({4'h0, 2'(i / 3), 2'(i % 3)}, (i % 4 == 0) ? 8'h21 : 8'h01,
           {28'h0, 2'(i / 3), 2'(i % 3)});
    end
    bus(OFS_MODE, 1'b0, 32'h0);
    chk("mode flags", 32'h50, rd);
    bus(OFS_CTRL, 1'b0, 32'h0);
    chk("control readback", 32'h0, rd);
    bus(8'h3c, 1'b1, 32'hffff_ffff);
    bus(8'h3c, 1'b0, 32'h0);
    chk("unmapped read", 32'h0, rd);
    finish_test;
  end
endmodule // assert_call_const_exec_unit_test
